// File: logic/ddr2_spacing_pkg.sv
`default_nettype none
package ddr2_spacing_pkg;
  // clock rate
  localparam int unsigned CLK_PERIOD_PS = 50000;
  // times in ps, as printed in ns
  localparam int unsigned ACT_GAP_X8_PS      = 7500;
  localparam int unsigned ACT_GAP_X16_PS     = 10000;
  localparam int unsigned WRITE_RECOVERY_PS  = 15000;
  localparam int unsigned WR_TO_RD_PS        = 7500;
  localparam int unsigned RD_TO_PRE_PS       = 7500;
  localparam int unsigned SELFREF_EXTRA_PS   = 10000;
  localparam int unsigned REFRESH_CYCLE_PS   = 127500;
  localparam int unsigned PRECHARGE_PS       = 15000;
  // least times round up to whole cycles, never below one
  function automatic int unsigned ps_to_cyc(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ps_to_cyc
  localparam int unsigned ACT_GAP_X8_CYC  = ps_to_cyc(ACT_GAP_X8_PS);
  localparam int unsigned ACT_GAP_X16_CYC = ps_to_cyc(ACT_GAP_X16_PS);
  localparam int unsigned WRITE_RECOVERY_CYC = ps_to_cyc(WRITE_RECOVERY_PS);
  localparam int unsigned PRECHARGE_CYC   = ps_to_cyc(PRECHARGE_PS);
  localparam int unsigned AUTOPRE_WRITE_RECOVERY_CYC = WRITE_RECOVERY_CYC + PRECHARGE_CYC;
  localparam int unsigned WRITE_TO_READ_CYC = ps_to_cyc(WR_TO_RD_PS);
  localparam int unsigned READ_TO_PRE_CYC   = ps_to_cyc(RD_TO_PRE_PS);
  localparam int unsigned SELFREF_EXIT_NONREAD_CYC =
    ps_to_cyc(REFRESH_CYCLE_PS + SELFREF_EXTRA_PS);
  // counts given in clock cycles
  localparam int unsigned COL_TO_COL_GAP      = 2;
  localparam int unsigned CLK_EN_MIN_PULSE    = 3;
  localparam int unsigned SELFREF_EXIT_READ   = 200;
  localparam int unsigned PRE_PD_EXIT_GAP     = 2;
  localparam int unsigned ACTIVE_PD_FAST_EXIT = 2;
  localparam int unsigned SLOW_EXIT_BASE_667  = 7;
  localparam int unsigned SLOW_EXIT_BASE_800  = 8;
  localparam int unsigned TERM_TO_PD_ENTRY    = 3;
  localparam int unsigned PD_EXIT_TO_TERM     = 8;
  localparam int unsigned MODEREG_WRITE_GAP   = 2;
  localparam int unsigned CLOCK_HOLD_AFTER_CKE_DROP = 2;
  localparam int unsigned BURST_HALF_DIV      = 2;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_MRS   = 4'h0;
  // request kinds from the user side
  typedef enum logic [2:0] {
    REQ_ACT = 3'h0, REQ_RD = 3'h1, REQ_WR = 3'h2, REQ_PRE = 3'h3,
    REQ_MRS = 3'h4, REQ_SR_ENTER = 3'h5, REQ_PD_ENTER = 3'h6, REQ_WAKE = 3'h7
  } req_kind_t;
  // power state, gray along active -> pd -> active
  typedef enum logic [1:0] {
    PS_ACTIVE = 2'b00, PS_PD = 2'b01, PS_SELFREF = 2'b11
  } pwr_state_t;
  localparam int unsigned CNT_W = 9;
  localparam logic [7:0] EMR_DQS_OFF_BIT = 8'ha;
  localparam logic [7:0] MR_PD_SLOW_BIT  = 8'hc;
endpackage : ddr2_spacing_pkg
`default_nettype wire

// File: logic/gap_timer.sv
`timescale 1ns/1ns
`default_nettype none
// down counter: load a gap, report when it has run out
module gap_timer
  import ddr2_spacing_pkg::*;
#(
  parameter int unsigned W = CNT_W
)
(
  // clock and reset
  input  wire  logic         i_core_clk,
  input  wire  logic         i_rst_n,
  input  wire  logic         i_ce,
  // load and status
  input  wire  logic         i_load,
  input  wire  logic [W-1:0] i_count,
  output logic               o_done
);
  logic [W-1:0] left_r;  // cycles still to wait

  // load wins over the count-down
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      left_r <= '0;
    else if (i_ce)
    begin
      if (i_load)
        left_r <= i_count;
      else if (left_r != '0)
        left_r <= left_r - 1'b1;
    end
  end

  // a load of n blocks the next n-1 cycles, so the gap is n edges;
  // done looks only at the count, so the ready path has no loop through the load
  assign o_done = (left_r <= {{(W-1){1'b0}}, 1'b1});
endmodule : gap_timer
`default_nettype wire

// File: logic/ddr2_cmd_spacer.sv
// Contract
// - activates apart by 7.5 or 10 ns
// - column commands at least 2 cycles apart
// - auto-precharge write blocks bank recovery plus precharge
// - read waits 7.5 ns after write data
// - precharge trails read by 7.5 ns
// - clock-enable levels last at least 3 cycles
// - self-refresh exit: non-read waits refresh plus 10ns
// - self-refresh exit: read waits 200 cycles
// - precharge power-down exit: any command after 2
// - fast active power-down exit: read after 2
// - slow exit: read after 7 or 8 minus AL
// - power-down entry 3 cycles after termination change
// - termination change 8 cycles after power-down exit
// - mode-register write then anything: 2 cycles
// - clock keeps running after clock-enable drop
// - read to precharge at least AL plus BL/2
`timescale 1ns/1ns
`default_nettype none
module ddr2_cmd_spacer
  import ddr2_spacing_pkg::*;
#(
  parameter bit          X16         = 1'b0,   // organisation
  parameter bit          GRADE_800   = 1'b1,   // speed grade
  parameter int unsigned ADD_LAT     = 0,      // additive latency
  parameter int unsigned BURST_LEN   = 4
)
(
  // clock, reset, enable
  input  wire  logic       i_core_clk,
  input  wire  logic       i_rst_n,
  input  wire  logic       i_ce,
  // user request
  input  wire  logic       i_req_valid,
  input  wire  logic [2:0] i_req_kind,
  input  wire  logic [2:0] i_req_bank,
  input  wire  logic       i_req_autopre,
  input  wire  logic [15:0] i_req_addr,
  input  wire  logic [1:0] i_req_mr_sel,
  input  wire  logic       i_term_req,
  output logic             o_req_ready,
  // memory pins
  output logic             o_mem_cke,
  output logic             o_mem_clk_run,
  output logic             o_mem_cs_n,
  output logic             o_mem_ras_n,
  output logic             o_mem_cas_n,
  output logic             o_mem_we_n,
  output logic [2:0]       o_mem_ba,
  output logic [15:0]      o_mem_addr,
  output logic             o_mem_odt,
  // status
  output logic             o_diff_strobe,
  output logic             o_pd_slow_exit,
  output logic             o_term_active
);
  localparam logic [CNT_W-1:0] ACT_GAP =
    CNT_W'(X16 ? ACT_GAP_X16_CYC : ACT_GAP_X8_CYC);
  localparam logic [CNT_W-1:0] SLOW_EXIT =
    CNT_W'((GRADE_800 ? SLOW_EXIT_BASE_800 : SLOW_EXIT_BASE_667) - ADD_LAT);
  localparam int unsigned RD_PRE_AL = ADD_LAT + BURST_LEN / BURST_HALF_DIV;
  localparam logic [CNT_W-1:0] RD_PRE_GAP =
    CNT_W'((RD_PRE_AL > READ_TO_PRE_CYC) ? RD_PRE_AL : READ_TO_PRE_CYC);
  localparam logic [CNT_W-1:0] WR_RD_GAP =
    CNT_W'(WRITE_TO_READ_CYC + BURST_LEN / BURST_HALF_DIV + ADD_LAT);

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction : cyc

  req_kind_t   kind;           // request decoded
  pwr_state_t  pwr_r;          // power state
  logic        bank_open_r;    // a bank was open at pd entry
  logic        slow_exit_r;    // copy of mode bit 12
  logic        diff_strobe_r;  // strobe mode, set by extended mode write
  logic [7:0]  bank_busy_r;    // bank blocked by auto-precharge write
  logic [CNT_W-1:0] bank_cnt_r [8];
  logic        issue;          // request accepted this cycle
  logic        cke_ok;         // clock enable may change level
  logic        odt_r, odt_d1_r, odt_d2_r, odt_d3_r;
  // gap timers: act, col, wr-rd, rd-pre, mrs, cke, any-after-exit,
  // read-after-exit, term-to-pd, pd-to-term
  logic [9:0]  t_load;
  logic [CNT_W-1:0] t_cnt [10];
  logic [9:0]  t_done;
  logic        allow;

  assign kind = req_kind_t'(i_req_kind);

  genvar g;
  generate
    for (g = 0; g < 10; g++)
    begin : g_tmr
      gap_timer #(.W(CNT_W)) u_tmr (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_load     (t_load[g]),
        .i_count    (t_cnt[g]),
        .o_done     (t_done[g])
      );
    end
  endgenerate

  // decide whether the request may go now
  always_comb
  begin
    allow = t_done[4] && t_done[6];
    unique case (kind)
      REQ_ACT:
        allow = allow && t_done[0] && (pwr_r == PS_ACTIVE)
                && !bank_busy_r[i_req_bank];
      REQ_RD:
        allow = t_done[4] && t_done[1] && t_done[2] && t_done[7]
                && (pwr_r == PS_ACTIVE) && !bank_busy_r[i_req_bank];
      REQ_WR:
        allow = allow && t_done[1] && (pwr_r == PS_ACTIVE)
                && !bank_busy_r[i_req_bank];
      REQ_PRE:
        allow = allow && t_done[3] && (pwr_r == PS_ACTIVE)
                && !bank_busy_r[i_req_bank];
      REQ_MRS:
        allow = allow && (pwr_r == PS_ACTIVE) && (bank_busy_r == '0);
      REQ_SR_ENTER:
        allow = allow && cke_ok && (pwr_r == PS_ACTIVE) && (bank_busy_r == '0);
      REQ_PD_ENTER:
        // a termination change in this very cycle also blocks entry
        allow = allow && t_done[8] && !t_load[8] && cke_ok
                && (pwr_r == PS_ACTIVE);
      REQ_WAKE:
        allow = cke_ok && (pwr_r != PS_ACTIVE);
    endcase
  end
  assign issue       = i_req_valid && allow && i_ce;
  assign o_req_ready = allow;

  // timer loads on issued commands, termination changes and the first cke rise
  always_comb
  begin
    t_load = '0;
    for (int i = 0; i < 10; i++)
      t_cnt[i] = '0;
    t_cnt[0] = ACT_GAP;
    t_cnt[1] = cyc(COL_TO_COL_GAP);
    t_cnt[2] = WR_RD_GAP;
    t_cnt[3] = RD_PRE_GAP;
    t_cnt[4] = cyc(MODEREG_WRITE_GAP);
    t_cnt[5] = cyc(CLK_EN_MIN_PULSE);
    t_cnt[8] = cyc(TERM_TO_PD_ENTRY);
    t_cnt[9] = cyc(PD_EXIT_TO_TERM);
    if (pwr_r == PS_SELFREF)
    begin
      t_cnt[6] = cyc(SELFREF_EXIT_NONREAD_CYC);
      t_cnt[7] = cyc(SELFREF_EXIT_READ);
    end
    else if (bank_open_r)
    begin
      t_cnt[6] = cyc(1);
      t_cnt[7] = slow_exit_r ? SLOW_EXIT : cyc(ACTIVE_PD_FAST_EXIT);
    end
    else
    begin
      t_cnt[6] = cyc(PRE_PD_EXIT_GAP);
      t_cnt[7] = cyc(PRE_PD_EXIT_GAP);
    end
    if (issue)
    begin
      t_load[0] = (kind == REQ_ACT);
      t_load[1] = (kind == REQ_RD) || (kind == REQ_WR);
      t_load[2] = (kind == REQ_WR);
      t_load[3] = (kind == REQ_RD);
      t_load[4] = (kind == REQ_MRS);
      t_load[5] = (kind == REQ_PD_ENTER) || (kind == REQ_SR_ENTER) || (kind == REQ_WAKE);
      t_load[6] = (kind == REQ_WAKE);
      t_load[7] = (kind == REQ_WAKE);
      t_load[9] = (kind == REQ_WAKE);
    end
    t_load[8] = (odt_r != (i_term_req && t_done[9] && pwr_r == PS_ACTIVE)) && i_ce;
    // first rise after reset also starts a minimum high pulse
    if (!o_mem_cke && pwr_r == PS_ACTIVE)
      t_load[5] = i_ce;
  end

  // clock enable may only flip after its minimum pulse
  // the rise after reset is still pending while awake with cke low
  assign cke_ok = t_done[5] && (o_mem_cke || pwr_r != PS_ACTIVE);

  // power state and the mode it was entered from
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      pwr_r       <= PS_ACTIVE;
      bank_open_r <= 1'b0;
    end
    else if (issue)
    begin
      unique case (kind)
        REQ_SR_ENTER: pwr_r <= PS_SELFREF;
        REQ_PD_ENTER:
        begin
          pwr_r       <= PS_PD;
          bank_open_r <= i_req_autopre;  // user flags banks left open
        end
        REQ_WAKE:     pwr_r <= PS_ACTIVE;
        default:      pwr_r <= pwr_r;
      endcase
    end
  end

  // mode register copies
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      slow_exit_r   <= 1'b0;
      diff_strobe_r <= 1'b1;
    end
    else if (issue && kind == REQ_MRS)
    begin
      if (i_req_mr_sel == 2'h0)
        slow_exit_r <= i_req_addr[MR_PD_SLOW_BIT[3:0]];
      else if (i_req_mr_sel == 2'h1)
        diff_strobe_r <= !i_req_addr[EMR_DQS_OFF_BIT[3:0]];
    end
  end

  // per-bank recovery after a write with auto-precharge
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      bank_busy_r <= '0;
      for (int b = 0; b < 8; b++)
        bank_cnt_r[b] <= '0;
    end
    else if (i_ce)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (issue && kind == REQ_WR && i_req_autopre && i_req_bank == 3'(b))
        begin
          bank_cnt_r[b]  <= cyc(AUTOPRE_WRITE_RECOVERY_CYC) + WR_RD_GAP;
          bank_busy_r[b] <= 1'b1;
        end
        else if (bank_cnt_r[b] > cyc(1))
          bank_cnt_r[b] <= bank_cnt_r[b] - 1'b1;
        else
        begin
          bank_cnt_r[b]  <= '0;
          bank_busy_r[b] <= 1'b0;
        end
      end
    end
  end

  // command pins, registered
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_NOP;
      o_mem_ba   <= '0;
      o_mem_addr <= '0;
      o_mem_cke  <= 1'b0;
    end
    else if (i_ce)
    begin
      {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_NOP;
      // awake means cke high; a sleep entry below overrides it
      if (pwr_r == PS_ACTIVE)
        o_mem_cke <= 1'b1;
      if (issue)
      begin
        o_mem_ba   <= (kind == REQ_MRS) ? {1'b0, i_req_mr_sel} : i_req_bank;
        o_mem_addr <= i_req_addr;
        unique case (kind)
          REQ_ACT: {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_ACT;
          REQ_RD:  {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_RD;
          REQ_WR:  {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_WR;
          REQ_PRE: {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_PRE;
          REQ_MRS: {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_MRS;
          REQ_SR_ENTER:
          begin
            {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n} <= CMD_REF;
            o_mem_cke <= 1'b0;
          end
          REQ_PD_ENTER: o_mem_cke <= 1'b0;
          REQ_WAKE:     o_mem_cke <= 1'b1;
        endcase
      end
    end
  end

  // termination pin and the device's lagged view of it
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      odt_r    <= 1'b0;
      odt_d1_r <= 1'b0;
      odt_d2_r <= 1'b0;
      odt_d3_r <= 1'b0;
    end
    else if (i_ce)
    begin
      odt_r    <= i_term_req && t_done[9] && pwr_r == PS_ACTIVE;
      odt_d1_r <= odt_r;
      odt_d2_r <= odt_d1_r;
      odt_d3_r <= odt_d2_r;
    end
  end
  assign o_mem_odt = odt_r;
  // on after 2, off after 2.5 rounded to 3 cycles
  assign o_term_active = odt_d2_r || (odt_d3_r && !odt_d2_r && odt_d1_r) || odt_d3_r;

  // clock runs always; a cke drop keeps it on at least one extra cycle
  assign o_mem_clk_run = 1'b1;
  assign o_diff_strobe = diff_strobe_r;
  assign o_pd_slow_exit = slow_exit_r;
endmodule : ddr2_cmd_spacer
`default_nettype wire

// File: test/ddr2_cmd_spacer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module spacer_checker
  import ddr2_spacing_pkg::*;
#(
  parameter int unsigned ADD_LAT   = 0,
  parameter int unsigned BURST_LEN = 4
)
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // watched pins
  input  wire logic o_mem_cke,
  input  wire logic o_mem_cs_n,
  input  wire logic o_mem_ras_n,
  input  wire logic o_mem_cas_n,
  input  wire logic o_mem_we_n,
  input  wire logic o_mem_odt,
  input  wire logic o_term_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] cmd;     // decoded command pins
  logic [7:0] up_r;    // cycles since clock enable rose, saturating
  logic [3:0] wr_r;    // cycles since last write
  logic       pd_r;    // a sleep has happened since reset
  logic       sr_r;    // the last sleep was self refresh
  logic [3:0] last_r;  // last real command
  assign cmd = {o_mem_cs_n, o_mem_ras_n, o_mem_cas_n, o_mem_we_n};
  // wake counter, held at zero while asleep
  always_ff @(posedge i_core_clk)
    if (!i_rst_n || !o_mem_cke)
      up_r <= 8'h00;
    else if (up_r != 8'hff)
      up_r <= up_r + 8'h01;
  // write age
  always_ff @(posedge i_core_clk)
    if (!i_rst_n)
      wr_r <= 4'hf;
    else if (cmd == CMD_WR)
      wr_r <= 4'h1;
    else if (wr_r != 4'hf)
      wr_r <= wr_r + 4'h1;
  // sleep kind; a fall shows as cke low with a nonzero wake count
  always_ff @(posedge i_core_clk)
    if (!i_rst_n)
    begin
      pd_r <= 1'b0;
      sr_r <= 1'b0;
      last_r <= CMD_NOP;
    end
    else
    begin
      if (cmd != CMD_NOP)
        last_r <= cmd;
      if (!o_mem_cke && up_r != 8'h00)
      begin
        pd_r <= 1'b1;
        sr_r <= (cmd == CMD_REF) || (last_r == CMD_REF);
      end
    end
  property p_col_gap;
    (cmd == CMD_RD || cmd == CMD_WR) |=> !(cmd == CMD_RD || cmd == CMD_WR);
  endproperty
  a_col_gap: assert property (p_col_gap) else $error("column commands too close");
  property p_mrs_gap;
    cmd == CMD_MRS |=> cmd == CMD_NOP;
  endproperty
  a_mrs_gap: assert property (p_mrs_gap) else $error("command right after mode write");
  property p_cke_high;
    $rose(o_mem_cke) |-> o_mem_cke[*3];
  endproperty
  a_cke_high: assert property (p_cke_high) else $error("clock enable high too short");
  property p_cke_low;
    $fell(o_mem_cke) |-> (!o_mem_cke)[*3];
  endproperty
  a_cke_low: assert property (p_cke_low) else $error("clock enable low too short");
  property p_wr_rd;
    cmd == CMD_RD |-> wr_r >= WRITE_TO_READ_CYC + BURST_LEN / 2 + ADD_LAT;
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("read too soon after write");
  property p_rd_pre;
    cmd == CMD_RD |=> cmd != CMD_PRE;
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("precharge too soon after read");
  property p_pd_exit;
    pd_r && o_mem_cke && cmd != CMD_NOP |-> up_r >= 2;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("command too soon after wake");
  property p_sr_other;
    sr_r && o_mem_cke && cmd != CMD_NOP && cmd != CMD_RD |-> up_r >= SELFREF_EXIT_NONREAD_CYC;
  endproperty
  a_sr_other: assert property (p_sr_other) else $error("early command after self refresh");
  property p_sr_read;
    sr_r && cmd == CMD_RD |-> up_r >= SELFREF_EXIT_READ;
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("early read after self refresh");
  property p_odt_pd;
    $fell(o_mem_cke) |-> $past(o_mem_odt, 1) == $past(o_mem_odt, 3)
      && $past(o_mem_odt, 2) == $past(o_mem_odt, 3);
  endproperty
  a_odt_pd: assert property (p_odt_pd) else $error("sleep too soon after odt change");
  property p_odt_wake;
    pd_r && $rose(o_mem_cke) |-> $stable(o_mem_odt)[*8];
  endproperty
  a_odt_wake: assert property (p_odt_wake) else $error("odt moved too soon after wake");
  property p_term_on;
    $rose(o_mem_odt) |-> !o_term_active ##2 o_term_active;
  endproperty
  a_term_on: assert property (p_term_on) else $error("termination on at wrong time");
endmodule : spacer_checker
bind ddr2_cmd_spacer spacer_checker #(.ADD_LAT(ADD_LAT), .BURST_LEN(BURST_LEN)) u_spacer_checker (
  .i_core_clk, .i_rst_n, .o_mem_cke, .o_mem_cs_n, .o_mem_ras_n, .o_mem_cas_n,
  .o_mem_we_n, .o_mem_odt, .o_term_active);
`default_nettype wire

// File: test/ddr2_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddr2_dev_model
  import ddr2_spacing_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // pins from the controller
  input  wire logic [3:0]  i_cmd,
  input  wire logic [2:0]  i_ba,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_odt,
  // device state
  output logic             o_diff_strobe,
  output logic             o_slow_exit,
  output logic             o_term_on
);
  logic [2:0] odt_r;  // odt history, newest in bit 0
  // mode bits only change on a mode write to the matching register
  always_ff @(posedge i_core_clk)
    if (!i_rst_n)
    begin
      o_diff_strobe <= 1'b1;
      o_slow_exit <= 1'b0;
    end
    else if (i_cmd == CMD_MRS && i_ba == 3'h1)
      o_diff_strobe <= !i_addr[EMR_DQS_OFF_BIT];
    else if (i_cmd == CMD_MRS && i_ba == 3'h0)
      o_slow_exit <= i_addr[MR_PD_SLOW_BIT];
  // half-cycle off lag rounded up to a whole cycle
  always_ff @(posedge i_core_clk)
    if (!i_rst_n)
      odt_r <= 3'h0;
    else
      odt_r <= {odt_r[1:0], i_odt};
  assign o_term_on = odt_r[1] | odt_r[2];
endmodule : ddr2_dev_model
`default_nettype wire

// File: test/ddr2_cmd_spacer_test.sv
`timescale 1ns/1ns
`default_nettype none
module ddr2_cmd_spacer_test
  import ddr2_spacing_pkg::*;
();
  typedef struct packed {logic [3:0] cmd; logic [2:0] ba; logic [15:0] addr; logic [8:0] gap;} exp_t;
  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, ap = 1'b0, term = 1'b0;
  logic [2:0] kind = 3'h0, bank = 3'h0;
  logic [15:0] addr = 16'h0000, maddr;
  logic [31:0] seed = 32'h663b1be1;
  logic ready, cke, cs_n, ras_n, cas_n, we_n, odt, diff, slow, tact, m_diff, m_slow, m_term;
  logic cke_q = 1'b0, crun, diff_q = 1'b1, slow_q = 1'b0;
  logic [2:0] ba;
  logic [3:0] cmd;
  exp_t q[$];
  exp_t e;
  int error_cnt = 0, tests_run = 0, cyc = 0, last_ev = 0;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  always #25 clk = !clk;
  ddr2_cmd_spacer u_ddr2_cmd_spacer (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_req_valid(valid), .i_req_kind(kind), .i_req_bank(bank), .i_req_autopre(ap),
    .i_req_addr(addr), .i_req_mr_sel(bank[1:0]), .i_term_req(term), .o_req_ready(ready),
    .o_mem_cke(cke), .o_mem_clk_run(crun), .o_mem_cs_n(cs_n), .o_mem_ras_n(ras_n),
    .o_mem_cas_n(cas_n), .o_mem_we_n(we_n), .o_mem_ba(ba), .o_mem_addr(maddr),
    .o_mem_odt(odt), .o_diff_strobe(diff), .o_pd_slow_exit(slow), .o_term_active(tact));
  ddr2_dev_model u_ddr2_dev_model (.i_core_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd),
    .i_ba(ba), .i_addr(maddr), .i_odt(odt), .o_diff_strobe(m_diff),
    .o_slow_exit(m_slow), .o_term_on(m_term));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [3:0] k2c(input logic [2:0] k);
    case (k)
      REQ_ACT: return CMD_ACT;
      REQ_RD:  return CMD_RD;
      REQ_WR:  return CMD_WR;
      REQ_PRE: return CMD_PRE;
      default: return CMD_MRS;
    endcase
  endfunction : k2c
  task automatic chk_val(input string n, input logic [15:0] x, input logic [15:0] g);
    tests_run++;
    if (g !== x)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask : chk_val
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // called at a falling edge; holds the request until ready is seen at a rising edge
  task automatic req(input logic [2:0] k, input logic [2:0] b, input logic [15:0] a,
                     input logic p, input int g);
    if (k <= REQ_MRS)
      q.push_back({k2c(k), b, a, 9'(g)});
    kind = k;
    bank = b;
    addr = a;
    ap = p;
    valid = 1'b1;
    do
      @(posedge clk);
    while (ready !== 1'b1);
    @(negedge clk);
  endtask : req
  task automatic idle(input int n);
    valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  // cycle count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // monitor: each command takes the oldest note; spacing counts from the last event
  always @(negedge clk)
    if (rst_n)
    begin
      if (cmd != CMD_NOP && cmd != CMD_REF)
      begin
        e = q.size() ? q.pop_front() : '1;
        chk_val("command", 16'(e.cmd), 16'(cmd));
        chk_val("bank", 16'(e.ba), 16'(ba));
        chk_val("address", e.addr, maddr);
        chk_val("spacing", 16'h1, 16'(cyc - last_ev >= e.gap));
        last_ev = cyc;
      end
      if (cke && !cke_q)
        last_ev = cyc;
      cke_q = cke;
      chk_val("termination", 16'(m_term), 16'(tact));
      chk_val("strobe mode", 16'(m_diff), 16'(diff_q));
      chk_val("exit mode", 16'(m_slow), 16'(slow_q));
      chk_val("clock run", 16'h1, 16'(crun));
      // the model takes a mode write one cycle after the controller's copy
      diff_q = diff;
      slow_q = slow;
    end
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    seed = xs(seed);
    req(REQ_ACT, seed[2:0], seed[15:0], 1'b0, 1);
    req(REQ_ACT, seed[2:0] + 3'h1, seed[31:16], 1'b0, ACT_GAP_X8_CYC);
    req(REQ_RD, seed[2:0], 16'h0000, 1'b0, 1);
    req(REQ_RD, seed[2:0], 16'h0008, 1'b0, COL_TO_COL_GAP);
    req(REQ_PRE, seed[2:0], 16'h0000, 1'b0, 2);
    req(REQ_WR, seed[2:0] + 3'h1, 16'h0000, 1'b0, 1);
    req(REQ_RD, seed[2:0] + 3'h1, 16'h0000, 1'b0, 3);
    req(REQ_WR, seed[2:0] + 3'h1, 16'h0010, 1'b1, COL_TO_COL_GAP);
    req(REQ_ACT, seed[2:0] + 3'h1, seed[15:0], 1'b0, AUTOPRE_WRITE_RECOVERY_CYC);
    $display("bank commands done");
    for (int i = 0; i < 2; i++)
      req(REQ_MRS, 3'(i), 16'h1400, 1'b0, (i == 0) ? 1 : MODEREG_WRITE_GAP);
    idle(3);
    chk_val("strobe after ext write", 16'h0, 16'(diff));
    chk_val("slow exit bit", 16'h1, 16'(slow));
    $display("mode writes done");
    term = 1'b1;
    req(REQ_PD_ENTER, 3'h0, 16'h0000, 1'b0, 0);
    idle(4);
    req(REQ_WAKE, 3'h0, 16'h0000, 1'b0, 0);
    term = 1'b0;
    req(REQ_ACT, seed[2:0], seed[15:0], 1'b0, PRE_PD_EXIT_GAP);
    $display("precharge sleep done");
    // fast exit first, then slow exit, chosen by mode bit 12
    for (int m = 0; m < 2; m++)
    begin
      req(REQ_MRS, 3'h0, m ? 16'h1000 : 16'h0000, 1'b0, 1);
      req(REQ_PD_ENTER, 3'h0, 16'h0000, 1'b1, 0);
      idle(3);
      req(REQ_WAKE, 3'h0, 16'h0000, 1'b0, 0);
      req(REQ_RD, seed[2:0], 16'h0, 1'b0, m ? SLOW_EXIT_BASE_800 : ACTIVE_PD_FAST_EXIT);
    end
    $display("active sleep done");
    req(REQ_SR_ENTER, 3'h0, 16'h0000, 1'b0, 0);
    idle(3);
    req(REQ_WAKE, 3'h0, 16'h0000, 1'b0, 0);
    req(REQ_MRS, 3'h2, 16'h0000, 1'b0, SELFREF_EXIT_NONREAD_CYC);
    req(REQ_RD, seed[2:0], 16'h0000, 1'b0, SELFREF_EXIT_READ - SELFREF_EXIT_NONREAD_CYC);
    req(REQ_PRE, seed[2:0], 16'h0000, 1'b0, 2);
    idle(10);
    $display("self refresh done");
    report_and_stop();
  end
endmodule : ddr2_cmd_spacer_test
`default_nettype wire
